// File: hdl/reset_irq_priority_resolver.sv
`timescale 1ns/1ps
`include "rirq_map.svh"

// Overview of operation
// - Watchdog timeout forces reset only while the watchdog disable bit is clear
// - Normal modes: reset vectors FFFE pin/power, FFFC clock monitor, FFFA watchdog
// - Special modes: reset vectors BFFE pin/power, BFFC clock monitor, BFFA watchdog
// - After reset, three cycles fetch the restart vector, then execution starts
// - Reset sets X, I and S bits of the condition code register
// - Reset loads the mapping initialisation register with $01
// - Reset clears timer count, prescaler, flags, enables; compares load $FFFF
// - Reset clears compare-1 mask, capture4/compare5 select and compare-5 pin bits
// - Reset clears periodic flag, enable, rate bits and disables the pulse accumulator
// - Reset selects shortest watchdog rate, enable follows the stored disable bit
// - Reset sets baud to $04, masks serial interrupts, 8-bit frame, all off
// - After reset transmit-empty and transmit-complete flags read 1
// - Reset disables synchronous serial port and clears converter power-up bit
// - Reset disables memory programming, loads promote select 0110, level-sensitive pin
// - Reset release latches special mode from inverse pin B, mode A from pin A
// - Special modes: writing mode bits switches the operating mode
// - Reset sets startup delay bit and clears clock monitor enable
// - Non-maskable order: power/pin, clock monitor, watchdog, NMI pin, illegal, trap
// - Default maskable order: pin, periodic, captures, compares, overflows, serial ports
// - Promote select field raises one maskable source above all others
// - Promoted source still obeys masks; its vector address does not change
// - Promote select accepts writes only while the general interrupt mask is set
// - Service fetches the vector of the highest-priority pending enabled source
// - Maskable sources are recognised only while the general mask is clear

module reset_irq_priority_resolver
  import rirq_pkg::*;
#(
  parameter int          NSRC     = 15,
  parameter int          NSERIAL  = 5,
  parameter logic [7:0]  CFG_INIT = `CONFIG_RESET
) (
  input  logic                CLK,
  input  logic                RSTN,
  input  logic                CE,
  input  logic [15:0]         ADDR,
  input  logic [7:0]          WDATA,
  input  logic                WR,
  input  logic                RD,
  output logic [7:0]          RDATA,
  input  logic                MODE_A,
  input  logic                MODE_B,
  input  logic                CLKMON_FAIL,
  input  logic                WDOG_TIMEOUT,
  input  logic                NMI_N,
  input  logic                ILLEGAL_OP,
  input  logic                SW_TRAP,
  input  logic                CCR_I,
  input  logic                CCR_X,
  input  logic                IRQ_N,
  input  logic [NSRC-1:1]     SRC_FLAG,
  input  logic [NSRC-1:1]     SRC_EN,
  input  logic [NSERIAL-1:0]  SERIAL_FLAG,
  input  logic [NSERIAL-1:0]  SERIAL_EN,
  input  logic                INT_ACK,
  output logic                CPU_RESET,
  output logic                FETCH_PHASE,
  output logic [15:0]         VEC_ADDR,
  output logic                VEC_VALID,
  output init_vals_t          INIT_VAL,
  output logic                SPECIAL_MODE,
  output logic                MODE_A_BIT,
  output logic                BOOT_ROM_READ,
  output logic                READ_VIS_ECLK,
  output logic                CLKMON_EN,
  output logic                OSC_DELAY,
  output logic                CONV_POWER,
  output logic                IRQ_EDGE_MODE
);

  seq_state_t   state_q;
  cause_t       cause_q;
  logic [1:0]   fcnt_q;
  logic [3:0]   psel_q;
  logic         boot_rom_read_bit_q, read_visibility_eclk_out_q, wdoff_q;
  logic [7:0]   config_q;
  logic         irq_prev_q, irq_pend_q;
  logic [3:0]   src_q;
  logic [NSRC-1:0] req;
  logic [3:0]   promo;
  logic [3:0]   best;
  logic         any_req;
  logic         cmf_rst, wdt_rst, int_rst;
  logic         nmi_req;
  logic [15:0]  vec_d;
  logic         prio_wr;

  // Maskable requests; index follows the default order
  assign req[0] = IRQ_EDGE_MODE ? irq_pend_q : ~IRQ_N;
  generate
    for (genvar g = 1; g < NSRC - 1; g++) begin : g_req
      assign req[g] = SRC_FLAG[g] & SRC_EN[g];
    end
  endgenerate
  assign req[NSRC-1] = |(SERIAL_FLAG & SERIAL_EN);

  // Internal reset causes
  assign cmf_rst = CLKMON_FAIL & CLKMON_EN;
  assign wdt_rst = WDOG_TIMEOUT & ~wdoff_q;
  assign int_rst = (cmf_rst | wdt_rst) & (state_q != S_HOLD);
  assign nmi_req = ~NMI_N & ~CCR_X;
  assign prio_wr = CE & WR & (ADDR == `ADDR_PRIO);

  function automatic logic [15:0] reset_vec(input cause_t c, input logic spec);
    logic [15:0] v;
    v = spec ? `VEC_RST_SPEC : `VEC_RST_NORM;
    if (c == CAUSE_CMF) v = spec ? `VEC_CMF_SPEC : `VEC_CMF_NORM;
    if (c == CAUSE_WDT) v = spec ? `VEC_WDT_SPEC : `VEC_WDT_NORM;
    return v;
  endfunction : reset_vec

  function automatic logic [15:0] mask_vec(input logic [3:0] idx);
    return `VEC_MASK_TOP - {11'h000, idx, 1'b0};
  endfunction : mask_vec

  // Promote code to default-order index; reserved code falls back to the pin
  always_comb begin
    case (psel_q)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: promo = psel_q + 4'hA;
      4'h5, 4'h6:                   promo = 4'h0;
      4'h7:                         promo = 4'h1;
      default:                      promo = psel_q - 4'h6;
    endcase
  end

  // Lowest index wins unless the promoted source is pending
  always_comb begin
    best    = 4'h0;
    any_req = |req;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) best = i[3:0];
    end
    if (req[promo]) best = promo;
  end

  always_comb begin
    vec_d = VEC_ADDR;
    if (state_q == S_HOLD) vec_d = reset_vec(cause_q, ~MODE_B);
    else if (nmi_req) vec_d = `VEC_NMI;
    else if (ILLEGAL_OP) vec_d = `VEC_ILLEGAL;
    else if (SW_TRAP) vec_d = `VEC_SWTRAP;
    else if (!CCR_I && any_req) vec_d = mask_vec(best);
  end

  // Reset sequencer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q     <= S_HOLD;
      cause_q     <= CAUSE_POR;
      fcnt_q      <= 2'h0;
      CPU_RESET   <= 1'b1;
      FETCH_PHASE <= 1'b0;
    end else if (CE) begin
      if (int_rst) begin
        state_q     <= S_HOLD;
        cause_q     <= cmf_rst ? CAUSE_CMF : CAUSE_WDT;
        CPU_RESET   <= 1'b1;
        FETCH_PHASE <= 1'b0;
      end else begin
        case (state_q)
          S_HOLD: begin
            state_q     <= S_FETCH;
            fcnt_q      <= 2'h0;
            CPU_RESET   <= 1'b0;
            FETCH_PHASE <= 1'b1;
          end
          S_FETCH: begin
            fcnt_q <= fcnt_q + 2'h1;
            if (fcnt_q == `FETCH_LAST) begin
              state_q     <= S_RUN;
              FETCH_PHASE <= 1'b0;
            end
          end
          default: state_q <= S_RUN;
        endcase
      end
    end
  end

  // Vector output; restart vector stands through the whole fetch
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      VEC_ADDR  <= `VEC_RST_NORM;
      VEC_VALID <= 1'b0;
      src_q     <= 4'h0;
    end else if (CE) begin
      if (state_q == S_RUN && !int_rst) begin
        VEC_ADDR  <= vec_d;
        VEC_VALID <= nmi_req | ILLEGAL_OP | SW_TRAP | (~CCR_I & any_req);
        src_q     <= best;
      end else if (state_q == S_HOLD && !int_rst) begin
        VEC_ADDR  <= vec_d;
        VEC_VALID <= 1'b1;
      end else if (state_q != S_FETCH) begin
        VEC_VALID <= 1'b0;
      end
    end
  end

  // Priority and mode register; mode bits latch as the hold phase ends
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      psel_q        <= `PSEL_RESET;
      SPECIAL_MODE  <= 1'b0;
      MODE_A_BIT    <= 1'b0;
      boot_rom_read_bit_q       <= 1'b0;
      read_visibility_eclk_out_q       <= 1'b0;
    end else if (CE) begin
      if (state_q == S_HOLD || int_rst) begin
        psel_q <= `PSEL_RESET;
        if (state_q == S_HOLD) begin
          SPECIAL_MODE <= ~MODE_B;
          MODE_A_BIT   <= MODE_A;
          boot_rom_read_bit_q      <= ~MODE_B & ~MODE_A;
          read_visibility_eclk_out_q      <= ~MODE_B & MODE_A;
        end
      end else if (prio_wr) begin
        if (CCR_I) psel_q <= WDATA[3:0];
        read_visibility_eclk_out_q <= WDATA[`PRIO_READ_VISIBILITY_ECLK_OUT];
        if (SPECIAL_MODE) begin
          SPECIAL_MODE <= WDATA[`PRIO_SPECIAL_MODE_BIT];
          MODE_A_BIT   <= WDATA[`PRIO_MDA];
          boot_rom_read_bit_q      <= WDATA[`PRIO_BOOT_ROM_READ_BIT] & WDATA[`PRIO_SPECIAL_MODE_BIT];
        end
      end
    end
  end

  assign BOOT_ROM_READ = boot_rom_read_bit_q;
  assign READ_VIS_ECLK = read_visibility_eclk_out_q;

  // Stored configuration survives internal resets, as nonvolatile bits would
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      config_q <= CFG_INIT;
    end else if (CE && WR && ADDR == `ADDR_CONFIG) begin
      config_q <= WDATA;
    end
  end

  assign wdoff_q = config_q[`CFG_WDOFF];

  // Option bits
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CONV_POWER    <= 1'b0;
      IRQ_EDGE_MODE <= 1'b0;
      OSC_DELAY     <= 1'b1;
      CLKMON_EN     <= 1'b0;
    end else if (CE) begin
      if (state_q == S_HOLD || int_rst) begin
        CONV_POWER    <= 1'b0;
        IRQ_EDGE_MODE <= 1'b0;
        OSC_DELAY     <= 1'b1;
        CLKMON_EN     <= 1'b0;
      end else if (WR && ADDR == `ADDR_OPTION) begin
        CONV_POWER    <= WDATA[`OPT_CONVERTER_POWER_UP_BIT];
        IRQ_EDGE_MODE <= WDATA[`OPT_IRQE];
        OSC_DELAY     <= WDATA[`OPT_DLY];
        CLKMON_EN     <= WDATA[`OPT_CME];
      end
    end
  end

  // Edge-mode pin latch; a new edge beats a same-cycle acknowledge
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_prev_q <= 1'b1;
      irq_pend_q <= 1'b0;
    end else if (CE) begin
      irq_prev_q <= IRQ_N;
      if (irq_prev_q && !IRQ_N) irq_pend_q <= 1'b1;
      else if (INT_ACK && src_q == 4'h0) irq_pend_q <= 1'b0;
    end
  end

  // Reset images for peripherals, zero while RSTN is low, valid from the first clock after
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      INIT_VAL <= '0;
    end else if (CE) begin
      INIT_VAL.ccr_xis        <= `INIT_CCR_XIS;
      INIT_VAL.map_init       <= `INIT_MAP;
      INIT_VAL.timer_count    <= `INIT_COUNT;
      INIT_VAL.compare_init   <= `INIT_COMPARE;
      INIT_VAL.timer_prescale <= `INIT_RATE;
      INIT_VAL.oc1_mask       <= `INIT_COMPARE1_PIN_ACTION_MASK;
      INIT_VAL.cap4_cmp5_sel  <= 1'b0;
      INIT_VAL.cmp5_pin_mode  <= `INIT_RATE;
      INIT_VAL.periodic_rate  <= `INIT_RATE;
      INIT_VAL.wdog_rate      <= `INIT_RATE;
      INIT_VAL.wdog_enable    <= ~wdoff_q;
      INIT_VAL.baud           <= `INIT_BAUD;
      INIT_VAL.frame_9bit     <= 1'b0;
      INIT_VAL.tx_empty       <= 1'b1;
      INIT_VAL.tx_complete    <= 1'b1;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= `ZERO_BYTE;
    end else if (CE) begin
      if (!RD) RDATA <= `ZERO_BYTE;
      else if (ADDR == `ADDR_PRIO)
        RDATA <= {boot_rom_read_bit_q, SPECIAL_MODE, MODE_A_BIT, read_visibility_eclk_out_q, psel_q};
      else if (ADDR == `ADDR_CONFIG) RDATA <= config_q;
      else if (ADDR == `ADDR_OPTION)
        RDATA <= {CONV_POWER, 1'b0, IRQ_EDGE_MODE, OSC_DELAY, CLKMON_EN, 3'h0};
      else if (ADDR == `ADDR_CAUSE) RDATA <= {6'h00, cause_q};
      else RDATA <= `ZERO_BYTE;
    end
  end

  // Checks assume CE held high
  chk_wdog_force: assert property (@(posedge CLK) disable iff (!RSTN || !CE)
    (state_q == S_RUN && WDOG_TIMEOUT && !wdoff_q) |=> CPU_RESET ##1 FETCH_PHASE)
    else $error("watchdog timeout did not force reset");
  chk_wdog_off: assert property (@(posedge CLK) disable iff (!RSTN || !CE)
    (state_q == S_RUN && WDOG_TIMEOUT && wdoff_q && !cmf_rst) |=> !CPU_RESET)
    else $error("disabled watchdog forced reset");
  chk_reset_vector: assert property (@(posedge CLK) disable iff (!RSTN || !CE)
    $rose(FETCH_PHASE) |-> VEC_ADDR == reset_vec(cause_q, SPECIAL_MODE))
    else $error("wrong reset vector for cause and mode");
  chk_fetch_len: assert property (@(posedge CLK) disable iff (!RSTN || !CE)
    ($rose(FETCH_PHASE) && !cmf_rst && !wdt_rst) |-> FETCH_PHASE[*3] ##1 !FETCH_PHASE)
    else $error("restart fetch not three cycles");
  chk_mode_latch: assert property (@(posedge CLK) disable iff (!RSTN || !CE)
    $fell(CPU_RESET) |-> (SPECIAL_MODE == !$past(MODE_B) && MODE_A_BIT == $past(MODE_A)))
    else $error("mode bits not latched at reset release");
  chk_psel_guard: assert property (@(posedge CLK) disable iff (!RSTN || !CE)
    (prio_wr && !CCR_I && state_q != S_HOLD && !int_rst) |=> psel_q == $past(psel_q))
    else $error("promote select changed while unmasked");
  chk_nmi_order: assert property (@(posedge CLK) disable iff (!RSTN || !CE)
    (state_q == S_RUN && nmi_req && !int_rst) |=> (VEC_ADDR == `VEC_NMI && VEC_VALID))
    else $error("NMI pin not served first");
  chk_mask_gate: assert property (@(posedge CLK) disable iff (!RSTN || !CE)
    (state_q == S_RUN && CCR_I && !nmi_req && !ILLEGAL_OP && !SW_TRAP && !int_rst)
    |=> !VEC_VALID)
    else $error("maskable source served while masked");
  chk_promote: assert property (@(posedge CLK) disable iff (!RSTN || !CE)
    (state_q == S_RUN && !CCR_I && req[promo] && !nmi_req && !ILLEGAL_OP && !SW_TRAP
     && !int_rst) |=> VEC_ADDR == mask_vec($past(promo)))
    else $error("promoted source not served first");

  cov_wdog_reset: cover property (@(posedge CLK) disable iff (!RSTN)
    CE && state_q == S_RUN && wdt_rst);
  cov_promoted: cover property (@(posedge CLK) disable iff (!RSTN)
    CE && state_q == S_RUN && !CCR_I && req[promo] && req[0] && promo != 4'h0);
  cov_serial: cover property (@(posedge CLK) disable iff (!RSTN)
    CE && state_q == S_RUN && !CCR_I && best == 4'hE);

endmodule : reset_irq_priority_resolver

// File: hdl/rirq_map.svh
`ifndef RIRQ_MAP_SVH
`define RIRQ_MAP_SVH

// Register byte addresses
`define ADDR_OPTION    16'h1039
`define ADDR_PRIO      16'h103C
`define ADDR_CAUSE     16'h103D
`define ADDR_CONFIG    16'h103F

// Field positions
`define PRIO_BOOT_ROM_READ_BIT     7
`define PRIO_SPECIAL_MODE_BIT      6
`define PRIO_MDA       5
`define PRIO_READ_VISIBILITY_ECLK_OUT     4
`define CFG_WDOFF      2
`define OPT_CONVERTER_POWER_UP_BIT       7
`define OPT_IRQE       5
`define OPT_DLY        4
`define OPT_CME        3

// Reset values
`define PSEL_RESET     4'h6
`define CONFIG_RESET   8'h00
`define ZERO_BYTE      8'h00

// Reset vectors, normal then special modes
`define VEC_RST_NORM   16'hFFFE
`define VEC_CMF_NORM   16'hFFFC
`define VEC_WDT_NORM   16'hFFFA
`define VEC_RST_SPEC   16'hBFFE
`define VEC_CMF_SPEC   16'hBFFC
`define VEC_WDT_SPEC   16'hBFFA

// Interrupt vectors
`define VEC_ILLEGAL    16'hFFF8
`define VEC_SWTRAP     16'hFFF6
`define VEC_NMI        16'hFFF4
`define VEC_MASK_TOP   16'hFFF2

// Restart fetch length, last count value
`define FETCH_LAST     2'h2

// Peripheral reset images
`define INIT_CCR_XIS   3'h7
`define INIT_MAP       8'h01
`define INIT_COUNT     16'h0000
`define INIT_COMPARE   16'hFFFF
`define INIT_BAUD      8'h04
`define INIT_COMPARE1_PIN_ACTION_MASK      8'h00
`define INIT_RATE      2'h0

`endif

// File: hdl/rirq_pkg.sv
package rirq_pkg;

  typedef enum {S_HOLD, S_FETCH, S_RUN} seq_state_t;

  typedef enum logic [1:0] {CAUSE_POR, CAUSE_CMF, CAUSE_WDT} cause_t;

  // Images that peripherals load while an internal reset holds them; all zero while RSTN is low
  typedef struct packed {
    logic [2:0]  ccr_xis;
    logic [7:0]  map_init;
    logic [15:0] timer_count;
    logic [15:0] compare_init;
    logic [7:0]  oc1_mask;
    logic        cap4_cmp5_sel;
    logic [1:0]  cmp5_pin_mode;
    logic [1:0]  timer_prescale;
    logic [1:0]  periodic_rate;
    logic [1:0]  wdog_rate;
    logic        wdog_enable;
    logic [7:0]  baud;
    logic        frame_9bit;
    logic        tx_empty;
    logic        tx_complete;
  } init_vals_t;

endpackage : rirq_pkg

// File: testbench/src_model.sv
`timescale 1ns/1ps
module src_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [14:0] pend,
  input  wire logic [14:0] ena,
  output logic             irq_n,
  output logic [14:1]      src_flag,
  output logic [14:1]      src_en,
  output logic [4:0]       ser_flag,
  output logic [4:0]       ser_en
);
  // Peripheral flags move only after an edge, as real sources update them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_n    <= 1'b1;
      src_flag <= 14'h0000;
      src_en   <= 14'h0000;
      ser_flag <= 5'h00;
      ser_en   <= 5'h00;
    end else begin
      irq_n    <= ~(pend[0] & ena[0]);
      src_flag <= {1'b0, pend[13:1]};
      src_en   <= {1'b0, ena[13:1]};
      // Stray flag on bit 0 has no enable, so it must never raise a request
      ser_flag <= {2'h0, pend[14], 2'h1};
      ser_en   <= {2'h0, ena[14], 2'h0};
    end
  end
endmodule : src_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import rirq_pkg::*;
  logic CLK, RSTN, WR, RD, MODE_A, MODE_B, CLKMON_FAIL, WDOG_TIMEOUT, NMI_N;
  logic ILLEGAL_OP, SW_TRAP, CCR_I, CCR_X, IRQ_N, CPU_RESET, FETCH_PHASE, VEC_VALID;
  logic SPECIAL_MODE, MODE_A_BIT, CLKMON_EN, OSC_DELAY, CONV_POWER, IRQ_EDGE_MODE;
  logic [15:0] ADDR, VEC_ADDR;
  logic [7:0]  WDATA, RDATA;
  logic [14:1] SRC_FLAG, SRC_EN;
  logic [4:0]  SERIAL_FLAG, SERIAL_EN;
  logic [14:0] pend, ena;
  init_vals_t  INIT_VAL;
  int          n_fail = 0;
  int          comparisons = 0;
  // Source index promoted by each select code
  localparam int PIDX[16] = '{10, 11, 12, 13, 14, 0, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9};

  reset_irq_priority_resolver u_dut (
    .CLK(CLK), .RSTN(RSTN), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .MODE_A(MODE_A), .MODE_B(MODE_B), .CLKMON_FAIL(CLKMON_FAIL),
    .WDOG_TIMEOUT(WDOG_TIMEOUT), .NMI_N(NMI_N), .ILLEGAL_OP(ILLEGAL_OP), .SW_TRAP(SW_TRAP),
    .CCR_I(CCR_I), .CCR_X(CCR_X), .IRQ_N(IRQ_N), .SRC_FLAG(SRC_FLAG), .SRC_EN(SRC_EN),
    .SERIAL_FLAG(SERIAL_FLAG), .SERIAL_EN(SERIAL_EN), .INT_ACK(1'b0),
    .CPU_RESET(CPU_RESET), .FETCH_PHASE(FETCH_PHASE), .VEC_ADDR(VEC_ADDR),
    .VEC_VALID(VEC_VALID), .INIT_VAL(INIT_VAL), .SPECIAL_MODE(SPECIAL_MODE),
    .MODE_A_BIT(MODE_A_BIT), .BOOT_ROM_READ(), .READ_VIS_ECLK(), .CLKMON_EN(CLKMON_EN),
    .OSC_DELAY(OSC_DELAY), .CONV_POWER(CONV_POWER), .IRQ_EDGE_MODE(IRQ_EDGE_MODE));

  src_model u_src (
    .clk(CLK), .rstn(RSTN), .pend(pend), .ena(ena), .irq_n(IRQ_N), .src_flag(SRC_FLAG),
    .src_en(SRC_EN), .ser_flag(SERIAL_FLAG), .ser_en(SERIAL_EN));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK); ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLK); WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CLK); ADDR <= a; RD <= 1'b1;
    @(posedge CLK); RD <= 1'b0;
    #1 chk({8'h00, RDATA}, {8'h00, exp});
  endtask : rd

  task automatic mask(input logic i);
    @(posedge CLK); CCR_I <= i;
  endtask : mask

  // Vector answers one edge after the request; two edges leave margin for the source model
  task automatic vec(input logic [15:0] e, input logic v);
    repeat (2) @(posedge CLK);
    #1;
    chk({15'h0000, VEC_VALID}, {15'h0000, v});
    if (v) chk(VEC_ADDR, e);
  endtask : vec

  task automatic fetch(input logic [15:0] e);
    int t;
    int n;
    t = 0;
    n = 0;
    do begin @(posedge CLK); #1; t++; end while (FETCH_PHASE !== 1'b1 && t < 20);
    chk(VEC_ADDR, e);
    while (FETCH_PHASE === 1'b1 && n < 20) begin @(posedge CLK); #1; n++; end
    chk(16'(n), 16'h0003);
  endtask : fetch

  task automatic pulse(input logic cm, input logic wd);
    @(posedge CLK); CLKMON_FAIL <= cm; WDOG_TIMEOUT <= wd;
    @(posedge CLK); CLKMON_FAIL <= 1'b0; WDOG_TIMEOUT <= 1'b0;
  endtask : pulse

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    #500_000;
    n_fail++;
    stop_test();
  end

  initial begin
    logic [7:0] mp [4] = '{8'hC6, 8'h76, 8'h26, 8'h06};
    {RSTN, WR, RD, CLKMON_FAIL, WDOG_TIMEOUT, ILLEGAL_OP, SW_TRAP} = '0;
    {NMI_N, CCR_I, CCR_X} = 3'h7;
    ADDR = 16'h0000; WDATA = 8'h00; pend = 15'h0000; ena = 15'h0000;
    for (int m = 0; m < 4; m++) begin
      @(posedge CLK); RSTN <= 1'b0; {MODE_B, MODE_A} <= 2'(m ^ (m >> 1));
      repeat (4) @(posedge CLK);
      #1 chk({15'h0000, CPU_RESET}, 16'h0001);
      @(posedge CLK); RSTN <= 1'b1;
      fetch(m < 2 ? 16'hBFFE : 16'hFFFE);
      rd(16'h103C, mp[m]);
      if (m == 0) begin
        wr(16'h103C, 8'h66);
        #1 chk({14'h0000, SPECIAL_MODE, MODE_A_BIT}, 16'h0003);
      end
    end
    if (INIT_VAL !== '{3'h7, 8'h01, 16'h0000, 16'hFFFF, 8'h00, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0,
                       1'b1, 8'h04, 1'b0, 1'b1, 1'b1}) begin
      n_fail++;
      $display("ERROR %0t peripheral reset images wrong", $time);
    end
    comparisons++;
    rd(16'h1039, 8'h10);
    rd(16'h103F, 8'h00);
    wr(16'h103D, 8'hFF);
    rd(16'h103D, 8'h00);
    rd(16'h1000, 8'h00);
    mask(0); wr(16'h103C, 8'h00);
    rd(16'h103C, 8'h06);
    mask(1); wr(16'h103C, 8'h80);
    rd(16'h103C, 8'h00);
    @(posedge CLK); pend <= 15'h7FFF; ena <= 15'h7FFF;
    for (int c = 0; c < 16; c++) begin
      mask(1); wr(16'h103C, 8'(c));
      mask(0); vec(16'(16'hFFF2 - 2 * PIDX[c]), 1'b1);
    end
    mask(1); wr(16'h103C, 8'h00);
    @(posedge CLK); ena[10] <= 1'b0; CCR_I <= 1'b0;
    vec(16'hFFF2, 1'b1);
    mask(1); wr(16'h103C, 8'h06);
    @(posedge CLK); ena <= 15'h7FFF; CCR_I <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      @(posedge CLK); pend <= 15'h7FFF << i;
      vec(16'(16'hFFF2 - 2 * i), 1'b1);
    end
    @(posedge CLK); ena[14] <= 1'b0;
    vec(16'h0000, 1'b0);
    @(posedge CLK); ena[14] <= 1'b1; pend <= 15'h7FFF; CCR_I <= 1'b1;
    vec(16'h0000, 1'b0);
    @(posedge CLK); SW_TRAP <= 1'b1;
    vec(16'hFFF6, 1'b1);
    @(posedge CLK); ILLEGAL_OP <= 1'b1;
    vec(16'hFFF8, 1'b1);
    @(posedge CLK); NMI_N <= 1'b0; CCR_X <= 1'b0;
    vec(16'hFFF4, 1'b1);
    @(posedge CLK); CCR_X <= 1'b1;
    vec(16'hFFF8, 1'b1);
    wr(16'h103F, 8'h04);
    pulse(1'b0, 1'b1);
    repeat (4) @(posedge CLK);
    #1 chk({15'h0000, CPU_RESET}, 16'h0000);
    wr(16'h103F, 8'h00);
    wr(16'h1039, 8'h08);
    #1 chk({15'h0000, CLKMON_EN}, 16'h0001);
    pulse(1'b1, 1'b1);
    fetch(16'hFFFC);
    rd(16'h103D, 8'h01);
    chk({14'h0000, CLKMON_EN, OSC_DELAY}, 16'h0001);
    pulse(1'b0, 1'b1);
    fetch(16'hFFFA);
    rd(16'h103D, 8'h02);
    stop_test();
  end
endmodule : tb
